/* rtl/serial_link_pkg.sv */
// Purpose: Shared constants and types for the serial link pair.
// Assumes: One serial bit slot per clock cycle of clk_i.
// Notes:   Lane l slot s carries parallel bit l*SLOTS+s.
package serial_link_pkg;

  // ***********************************************************
  // Link shape
  // ***********************************************************
  localparam int LANES      = 4;
  localparam int SLOTS      = 7;
  localparam int WORD_W     = LANES * SLOTS;
  localparam int FCLK_HIGH  = 4;
  localparam int FIFO_DEPTH = 16;

  // ***********************************************************
  // Receiver timing counts: lock in clock periods, the rest in clk_i cycles
  // ***********************************************************
  localparam logic [3:0] LOCK_PERIODS = 4'h4;
  localparam logic [1:0] STROBE_LOW   = 2'h3;
  localparam logic [2:0] LAST_SLOT    = 3'h6;
  localparam logic [2:0] GAP_SLOT     = 3'h7;

  // Receiver lock states.
  typedef enum logic [1:0] {
    RX_HUNT = 2'b01,
    RX_LOCK = 2'b10
  } rx_state_t;

endpackage : serial_link_pkg

/* rtl/fifo_if.sv */
// Purpose: Valid/ready carrier between a producer, the word FIFO and a consumer.
// Assumes: Single clock domain.
// Notes:   A transfer happens when valid and ready are both high.
`timescale 1ns/1ps
interface fifo_if #(parameter int W = 28);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;

  modport buffer (input push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data);
  modport user   (output push_valid, push_data, pop_ready,
                  input push_ready, pop_valid, pop_data);
endinterface : fifo_if

/* rtl/word_fifo.sv */
// Purpose: Synchronous word FIFO with honest full and empty.
// Assumes: Depth is a power of two.
// Notes:   Pop data is the head entry, valid while not empty.
`timescale 1ns/1ps
module word_fifo #(
  parameter int W = 28,
  parameter int D = 16
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Data path.
  fifo_if.buffer    q
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wr;
    logic [AW-1:0]       rd;
    logic [AW:0]         cnt;
  } fifo_state_t;

  fifo_state_t s_ff;
  fifo_state_t nxt_s;
  logic        do_push;
  logic        do_pop;

  // ***********************************************************
  // Flags and next state
  // ***********************************************************
  assign q.push_ready = (s_ff.cnt != (AW+1)'(D));
  assign q.pop_valid  = (s_ff.cnt != '0);
  assign q.pop_data   = s_ff.mem[s_ff.rd];
  assign do_push      = q.push_valid && q.push_ready;
  assign do_pop       = q.pop_ready && q.pop_valid;

  // Pointers wrap naturally since depth is a power of two.
  always_comb begin
    nxt_s = s_ff;
    if (do_push) begin
      nxt_s.mem[s_ff.wr] = q.push_data;
      nxt_s.wr           = s_ff.wr + 1'b1;
    end
    if (do_pop) begin
      nxt_s.rd = s_ff.rd + 1'b1;
    end
    nxt_s.cnt = s_ff.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  // State register.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule : word_fifo

/* rtl/serial_link_pair.sv */
// Purpose: Transmit serializer and receive deserializer of a 28-bit serial link.
// Assumes: clk_i at 125 MHz; one serial slot per cycle; link pins are asynchronous.
// Notes:   Every pin input passes two flip-flops; all outputs are registered.
`timescale 1ns/1ps

// Notes on behaviour
// - Each captured word fills fixed lane slots.
// - Word captured on parallel strobe rising edge.
// - Four data lanes, true and complement.
// - Forwarded clock lane derived from slot counter.
// - Sleep low releases all serial outputs.
// - Receiver deserializes four data lanes.
// - Forwarded clock times receive sampling.
// - Recovered word keeps transmit bit order.
// - Output strobe rising marks valid data.
// - Receiver sleep forces parallel outputs low.
// - Seven evenly spaced slots per clock period.
// - Latency from capture to output varies with queue fill and slot phase.
// - Failsafe: open data high, lost clock holds.
module serial_link_pair
  import serial_link_pkg::*;
#(
  parameter logic [3:0] LOCK_N = LOCK_PERIODS
) (
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Power control, active low.
  input  wire logic              sleep_n_i,
  // Transmit parallel side.
  input  wire logic [WORD_W-1:0] par_data_in_i,
  input  wire logic              par_strobe_in_i,
  output logic                   tx_ready_o,
  // Transmit serial lanes.
  output logic [LANES-1:0]       ser_data_out_p_o,
  output logic [LANES-1:0]       ser_data_out_n_o,
  output logic [LANES-1:0]       ser_data_out_oe_o,
  output logic                   fwd_clk_out_p_o,
  output logic                   fwd_clk_out_n_o,
  output logic                   fwd_clk_out_oe_o,
  // Receive serial lanes, true side of each pair.
  input  wire logic [LANES-1:0]  ser_data_in_i,
  input  wire logic              fwd_clk_in_i,
  // Receive parallel side.
  output logic [WORD_W-1:0]      par_data_out_o,
  output logic                   par_strobe_out_o
);

  typedef struct packed {
    logic [1:0]        slp;
    logic [2:0]        stb;
    logic [WORD_W-1:0] din1;
    logic [WORD_W-1:0] din2;
    logic [WORD_W-1:0] tword;
    logic [2:0]        tslot;
    logic [LANES-1:0]  sdp;
    logic [LANES-1:0]  sdn;
    logic [LANES-1:0]  soe;
    logic              fcp;
    logic              fcn;
    logic              foe;
    logic              trdy;
    logic [LANES:0]    rin1;
    logic [LANES:0]    rin2;
    logic              rclk3;
    logic [2:0]        rslot;
    logic [WORD_W-1:0] rword;
    logic [3:0]        good;
    rx_state_t         rst;
    logic [1:0]        pcnt;
    logic [WORD_W-1:0] pdata;
    logic              pstb;
  } link_state_t;

  link_state_t s_ff;
  link_state_t nxt_s;
  logic        awake;
  logic        tx_edge;
  logic        rx_edge;
  logic [2:0]  rx_idx;
  logic        rx_done;

  fifo_if #(.W(WORD_W)) txq ();

  // ***********************************************************
  // Transmit buffer
  // ***********************************************************
  word_fifo #(
    .W (WORD_W),
    .D (FIFO_DEPTH)
  ) u_txq (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .q     (txq.buffer)
  );

  // Synchronised pin levels and edges.
  assign awake   = s_ff.slp[1];
  assign tx_edge = s_ff.stb[1] && !s_ff.stb[2];
  assign rx_edge = s_ff.rin2[LANES] && !s_ff.rclk3;
  assign rx_idx  = rx_edge ? 3'h0 : s_ff.rslot;
  assign rx_done = !rx_edge && (s_ff.rslot == LAST_SLOT);

  // Capture on strobe rising edge; a refused word is lost, so honour tx_ready_o.
  assign txq.push_valid = tx_edge && awake;
  assign txq.push_data  = s_ff.din2;
  assign txq.pop_ready  = awake && (s_ff.tslot == LAST_SLOT);

  // ***********************************************************
  // Next state
  // ***********************************************************
  always_comb begin
    nxt_s = s_ff;
    // Two-stage synchronisers for every pin input.
    nxt_s.slp  = {s_ff.slp[0], sleep_n_i};
    nxt_s.stb  = {s_ff.stb[1:0], par_strobe_in_i};
    nxt_s.din1 = par_data_in_i;
    nxt_s.din2 = s_ff.din1;
    nxt_s.rin1 = {fwd_clk_in_i, ser_data_in_i};
    nxt_s.rin2 = s_ff.rin1;
    nxt_s.rclk3 = s_ff.rin2[LANES];
    nxt_s.trdy = txq.push_ready;

    // Transmit: slot counter is the bit-rate divider; one word per seven slots.
    if (awake) begin
      nxt_s.tslot = (s_ff.tslot == LAST_SLOT) ? 3'h0 : s_ff.tslot + 3'h1;
      if (txq.pop_ready && txq.pop_valid) begin
        nxt_s.tword = txq.pop_data;
      end
      for (int l = 0; l < LANES; l++) begin
        nxt_s.sdp[l] = s_ff.tword[l*SLOTS + int'(s_ff.tslot)];
        nxt_s.sdn[l] = ~s_ff.tword[l*SLOTS + int'(s_ff.tslot)];
      end
      nxt_s.soe = '1;
      nxt_s.fcp = (int'(s_ff.tslot) < FCLK_HIGH);
      nxt_s.fcn = !(int'(s_ff.tslot) < FCLK_HIGH);
      nxt_s.foe = 1'b1;
    end else begin
      // Sleep: drivers released and the serializer parked at slot zero.
      nxt_s.tslot = 3'h0;
      nxt_s.sdp   = '0;
      nxt_s.sdn   = '0;
      nxt_s.soe   = '0;
      nxt_s.fcp   = 1'b0;
      nxt_s.fcn   = 1'b0;
      nxt_s.foe   = 1'b0;
    end

    // Receive: forwarded clock rise marks slot zero of the period.
    if (rx_edge) begin
      nxt_s.rslot = 3'h1;
    end else if (s_ff.rslot != GAP_SLOT) begin
      nxt_s.rslot = s_ff.rslot + 3'h1;
    end
    if (rx_idx != GAP_SLOT) begin // A late clock must not spill into the next lane.
      for (int l = 0; l < LANES; l++) begin
        nxt_s.rword[l*SLOTS + int'(rx_idx)] = s_ff.rin2[l];
      end
    end

    // Lock tracking: an edge exactly seven cycles after the last counts as good.
    if (rx_edge) begin
      if (s_ff.rslot == GAP_SLOT && s_ff.good != 4'hF) begin
        nxt_s.good = s_ff.good + 4'h1;
      end else if (s_ff.rslot != GAP_SLOT) begin
        nxt_s.good = 4'h0;
      end
    end else if (s_ff.rslot == GAP_SLOT) begin
      nxt_s.good = 4'h0;
    end
    // Sleep forgets the lock, so waking up always hunts again.
    if (!awake) begin
      nxt_s.good = 4'h0;
    end
    if (!awake || nxt_s.good == 4'h0) begin
      nxt_s.rst = RX_HUNT;
    end else if (nxt_s.good >= LOCK_N) begin
      nxt_s.rst = RX_LOCK;
    end

    // Parallel output side.
    unique case (s_ff.rst)
      RX_HUNT: begin
        // A low run already begun finishes, so a lost clock never clips the strobe.
        if (s_ff.pcnt != 2'h0) begin
          nxt_s.pcnt = (s_ff.pcnt == STROBE_LOW) ? 2'h0 : s_ff.pcnt + 2'h1;
          nxt_s.pstb = (s_ff.pcnt == STROBE_LOW);
        end else begin
          nxt_s.pstb = 1'b1;
        end
      end
      RX_LOCK: begin
        if (rx_done) begin
          nxt_s.pdata = nxt_s.rword;
          nxt_s.pstb  = 1'b0;
          nxt_s.pcnt  = 2'h1;
        end else if (s_ff.pcnt != 2'h0) begin
          nxt_s.pcnt = (s_ff.pcnt == STROBE_LOW) ? 2'h0 : s_ff.pcnt + 2'h1;
          nxt_s.pstb = (s_ff.pcnt == STROBE_LOW);
        end
      end
      default: begin
        nxt_s.pstb = 1'b1;
        nxt_s.pcnt = 2'h0;
      end
    endcase
    if (!awake) begin
      nxt_s.pdata = '0;
      nxt_s.pstb  = 1'b0;
      nxt_s.pcnt  = 2'h0;
    end
  end

  // State register.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_ff     <= '0;
      s_ff.rst <= RX_HUNT;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************
  assign tx_ready_o        = s_ff.trdy;
  assign ser_data_out_p_o  = s_ff.sdp;
  assign ser_data_out_n_o  = s_ff.sdn;
  assign ser_data_out_oe_o = s_ff.soe;
  assign fwd_clk_out_p_o   = s_ff.fcp;
  assign fwd_clk_out_n_o   = s_ff.fcn;
  assign fwd_clk_out_oe_o  = s_ff.foe;
  assign par_data_out_o    = s_ff.pdata;
  assign par_strobe_out_o  = s_ff.pstb;

  // ***********************************************************
  // Checks
  // ***********************************************************
  sequence fclk_high_run;
    fwd_clk_out_p_o [*4];
  endsequence

  sequence fclk_low_run;
    !fwd_clk_out_p_o [*3];
  endsequence

  sequence strobe_low_run;
    !par_strobe_out_o [*3];
  endsequence

  chk_sleep_release: assert property (@(posedge clk_i) disable iff (rst_i)
    !awake |=> (ser_data_out_oe_o == '0) && !fwd_clk_out_oe_o)
    else $error("serial drivers enabled during sleep");

  chk_pair_complement: assert property (@(posedge clk_i) disable iff (rst_i)
    ser_data_out_oe_o[0] |-> (ser_data_out_n_o == ~ser_data_out_p_o))
    else $error("lane complement mismatch");

  chk_fclk_shape: assert property (@(posedge clk_i) disable iff (rst_i || !awake)
    $rose(fwd_clk_out_p_o) |-> fclk_high_run ##1 fclk_low_run ##1 fwd_clk_out_p_o)
    else $error("forwarded clock period not 4 high 3 low");

  chk_pop_slot: assert property (@(posedge clk_i) disable iff (rst_i)
    (txq.pop_ready && txq.pop_valid) |-> s_ff.tslot == LAST_SLOT ##7
      (s_ff.tslot == LAST_SLOT || !awake))
    else $error("word taken off slot boundary");

  chk_strobe_push: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_edge && awake && txq.push_ready) |=> (u_txq.s_ff.cnt != '0))
    else $error("strobe edge did not store a word");

  chk_rx_sleep_low: assert property (@(posedge clk_i) disable iff (rst_i)
    !awake |=> (par_data_out_o == '0) && !par_strobe_out_o)
    else $error("receiver outputs not low in sleep");

  chk_hunt_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_ff.rst == RX_HUNT && awake && $past(awake)) |=> $stable(par_data_out_o))
    else $error("data changed while unlocked");

  chk_strobe_after: assert property (@(posedge clk_i) disable iff (rst_i || !awake)
    (s_ff.rst == RX_LOCK && rx_done) |=> strobe_low_run ##1 par_strobe_out_o)
    else $error("strobe did not rise three cycles after data");

  chk_lock_period: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_ff.rst == RX_LOCK && rx_edge && s_ff.rslot != GAP_SLOT) |=> (s_ff.rst == RX_HUNT))
    else $error("off-period clock edge kept lock");

  chk_gap_hunt: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_ff.rslot == GAP_SLOT && !rx_edge) |=> (s_ff.rst == RX_HUNT))
    else $error("lock kept with clock absent");

  chk_hunt_strobe: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_ff.rst == RX_HUNT && awake && s_ff.pcnt == 2'h0) |=> par_strobe_out_o)
    else $error("strobe not high while unlocked");

  chk_sleep_hunt: assert property (@(posedge clk_i) disable iff (rst_i)
    !awake |=> (s_ff.rst == RX_HUNT) && (s_ff.good == 4'h0))
    else $error("receiver lock survived sleep");

  chk_slot_clock: assert property (@(posedge clk_i) disable iff (rst_i)
    (awake && s_ff.tslot == 3'h0) |=> fwd_clk_out_p_o)
    else $error("forwarded clock low at slot zero");

endmodule : serial_link_pair

/* dv/far_tx_model.sv */
// Purpose: Far-end transmitter that drives the receive lanes of the link.
// Assumes: One serial slot per clk_i cycle, seven slots per period.
// Notes:   mode_i 0 sends word_i, 1 leaves data open, 2 leaves data and clock open.
`timescale 1ns/1ps
module far_tx_model
  import serial_link_pkg::*;
(
  // Clock and control.
  input  wire logic              clk_i,
  input  wire logic [1:0]        mode_i,
  input  wire logic [WORD_W-1:0] word_i,
  // Lanes toward the receiver.
  output logic [LANES-1:0]       lane_o,
  output logic                   fclk_o
);
  logic [2:0]        slot_ff = 3'h0;
  logic [WORD_W-1:0] hold_ff = 28'h0;

  // Slot counter; a new word is taken only at a period boundary.
  always_ff @(posedge clk_i) begin
    slot_ff <= (slot_ff >= 3'h6) ? 3'h0 : slot_ff + 3'h1;
    if (slot_ff >= 3'h6) begin
      hold_ff <= word_i;
    end
  end

  // Open inputs float high, so failsafe shows as all ones.
  always_comb begin
    fclk_o = (mode_i == 2'h2) ? 1'b1 : (slot_ff < 3'h4);
    for (int l = 0; l < LANES; l++) begin
      lane_o[l] = (mode_i != 2'h0) ? 1'b1 : hold_ff[l*SLOTS+int'(slot_ff)];
    end
  end
endmodule : far_tx_model

/* dv/test_serial_link_pair.sv */
// Purpose: Self-checking bench for the serial link pair.
// Assumes: Inputs change 1 ns after the rising edge of clk_i.
// Notes:   Lock count is shortened to one period.
`timescale 1ns/1ps
module test_serial_link_pair;
  import serial_link_pkg::*;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              sleep_n_i = 1'b1;
  logic [WORD_W-1:0] par_data_in_i = 28'h0;
  logic              par_strobe_in_i = 1'b0;
  logic [1:0]        mode = 2'h0;
  logic [WORD_W-1:0] far_word = 28'h0;
  logic              tx_ready_o, fwd_clk_out_p_o, fwd_clk_out_n_o, fwd_clk_out_oe_o;
  logic              par_strobe_out_o, fclk;
  logic [LANES-1:0]  ser_data_out_p_o, ser_data_out_n_o, ser_data_out_oe_o, lane;
  logic [WORD_W-1:0] par_data_out_o;
  int                err_total = 0;
  int                compares = 0;

  // Free-running 125 MHz clock.
  always #4 clk_i = ~clk_i;

  serial_link_pair #(.LOCK_N(4'h1)) u_dut (
    .clk_i, .rst_i, .sleep_n_i, .par_data_in_i, .par_strobe_in_i, .tx_ready_o,
    .ser_data_out_p_o, .ser_data_out_n_o, .ser_data_out_oe_o,
    .fwd_clk_out_p_o, .fwd_clk_out_n_o, .fwd_clk_out_oe_o,
    .ser_data_in_i(lane), .fwd_clk_in_i(fclk), .par_data_out_o, .par_strobe_out_o
  );

  far_tx_model u_far (.clk_i(clk_i), .mode_i(mode), .word_i(far_word), .lane_o(lane),
    .fclk_o(fclk));

  // ***********************************************************
  // Shared tasks
  // ***********************************************************
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  function automatic logic pick(input int sel);
    return (sel == 0) ? fwd_clk_out_p_o : (sel == 1) ? par_strobe_out_o : fclk;
  endfunction : pick

  // Bounded wait for a level on the sent clock, the output strobe or the received clock.
  task automatic wait_lvl(input int sel, input logic v);
    int n;
    n = 0;
    while (pick(sel) !== v && n < 60) begin
      step(1);
      n++;
    end
    check({27'h0, pick(sel)}, {27'h0, v});
  endtask : wait_lvl

  // Data is held two cycles before and several after the strobe rise.
  task automatic push(input logic [WORD_W-1:0] w, input int hi);
    par_data_in_i = w;
    step(2);
    par_strobe_in_i = 1'b1;
    step(hi);
    par_strobe_in_i = 1'b0;
    step(2);
  endtask : push

  // Catches the next output strobe rise and compares the word.
  task automatic rx_catch(input logic [WORD_W-1:0] w);
    wait_lvl(1, 1'b0);
    wait_lvl(1, 1'b1);
    check(par_data_out_o, w);
  endtask : rx_catch

  // ***********************************************************
  // Scenarios
  // ***********************************************************
  task automatic t_tx_lanes(input logic [WORD_W-1:0] w);
    logic [WORD_W-1:0] got;
    push(w, 3);
    step(20);
    wait_lvl(0, 1'b0);
    wait_lvl(0, 1'b1);
    for (int s = 0; s < SLOTS; s++) begin
      for (int l = 0; l < LANES; l++) begin
        got[l*SLOTS+s] = ser_data_out_p_o[l];
      end
      check({24'h0, ser_data_out_n_o}, {24'h0, ~ser_data_out_p_o});
      check({24'h0, ser_data_out_oe_o}, 28'hF);
      check({27'h0, fwd_clk_out_p_o}, {27'h0, s < 4});
      check({26'h0, fwd_clk_out_n_o, fwd_clk_out_oe_o}, {26'h0, s >= 4, 1'b1});
      step(1);
    end
    check(got, w);
  endtask : t_tx_lanes

  // Latency is counted from the received clock rise of a new word to its output.
  task automatic t_rx(input logic [WORD_W-1:0] w);
    int n;
    far_word = w;
    mode = 2'h0;
    step(30);
    rx_catch(w);
    rx_catch(w);
    far_word = ~w;
    wait_lvl(2, 1'b0);
    wait_lvl(2, 1'b1);
    n = 0;
    while (par_data_out_o !== ~w && n < 30) begin
      step(1);
      n++;
    end
    check(28'(n), 28'h9);
    rx_catch(~w);
  endtask : t_rx

  task automatic t_failsafe;
    mode = 2'h1;
    step(20);
    rx_catch(28'hFFFFFFF);
    mode = 2'h2;
    step(30);
    check({27'h0, par_strobe_out_o}, 28'h1);
    check(par_data_out_o, 28'hFFFFFFF);
  endtask : t_failsafe

  task automatic t_sleep;
    sleep_n_i = 1'b0;
    step(4);
    check({ser_data_out_p_o, ser_data_out_n_o, ser_data_out_oe_o, fwd_clk_out_p_o,
      fwd_clk_out_n_o, fwd_clk_out_oe_o, 13'h0}, 28'h0);
    check(par_data_out_o, 28'h0);
    check({27'h0, par_strobe_out_o}, 28'h0);
    sleep_n_i = 1'b1;
    step(4);
  endtask : t_sleep

  // Pushes faster than the lanes drain until the queue refuses.
  task automatic t_fill;
    int n;
    n = 0;
    while (tx_ready_o === 1'b1 && n < 150) begin
      push({24'hA5A5A5, n[3:0]}, 2);
      n++;
    end
    check({27'h0, tx_ready_o}, 28'h0);
  endtask : t_fill

  task automatic summarize;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  // Main sequence; the last lane check proves the queue drained.
  initial begin
    step(5);
    rst_i = 1'b0;
    step(3);
    t_tx_lanes(28'h9C3A5E1);
    t_tx_lanes(28'h63C5A1E);
    t_rx(28'h5B1C7E3);
    t_rx(28'hA4E381C);
    t_failsafe;
    t_sleep;
    t_rx(28'h0F0F0F0);
    t_fill;
    step(140);
    t_tx_lanes(28'h3D2B6F4);
    summarize;
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #100000;
    err_total++;
    summarize;
  end
endmodule : test_serial_link_pair
